//--- pkg/sba_cfg.svh
// constants for the serial bus arbiter and bit timer
// assumes inclusion by bare name from rtl and verification files
`ifndef SBA_CFG_SVH
`define SBA_CFG_SVH
`define SBA_ADDR_CTL      12'h000
`define SBA_ADDR_DAT      12'h004
`define SBA_ADDR_IRQ_STAT 12'h008
`define SBA_ADDR_IRQ_EN   12'h00C
`define SBA_ADDR_IRQ_CLR  12'h010
`define SBA_CTL_OVFL      7
`define SBA_CTL_RUN       6
`define SBA_CTL_FIN       5
`define SBA_CTL_CLK       4
`define SBA_CTL_LOST      3
`define SBA_CTL_MSB       2
`define SBA_CTL_MODE_HI   1
`define SBA_CTL_MODE_LO   0
`define SBA_MODE_IDLE     2'b00
`define SBA_MODE_MEASURE  2'b01
`define SBA_MODE_ARB      2'b10
`define SBA_SAMPLE_BUS    9'h038
`define SBA_SAMPLE_PRE    9'h008
`define SBA_QUARTER       2'h3
`define SBA_IRQ_FIN       0
`define SBA_IRQ_OVFL      1
`define SBA_IRQ_LOST      2
`define SBA_IRQ_W         3
`endif

//--- pkg/sba_pkg.sv
// types for the serial bus arbiter and bit timer
// uses no macros from the cfg header and does not include it
package sba_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sba_apb_req_t;

    typedef struct packed {
        logic        ovfl;
        logic        run;
        logic        fin;
        logic        clk_sel;
        logic        lost;
        logic [8:0]  count;
        logic [1:0]  mode;
    } sba_stat_t;
endpackage : sba_pkg

//--- rtl/sba_tick.sv
// quarter-rate tick generator for the arbiter counter
// assumes the prescaled serial clock is given as a one-cycle enable pulse
`timescale 1ns/1ps
`include "sba_cfg.svh"
module sba_tick (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_sel,
    input  wire logic prescaled_tick,
    input  wire logic clear,
    output logic      tick
);
    logic [1:0] div_reg;
    logic       src;

    // pick the source that feeds the divide-by-four
    assign src = clk_sel ? prescaled_tick : 1'b1;

    // divide the chosen source by four; clear realigns the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
            tick    <= 1'b0;
        end else if (clear) begin
            div_reg <= 2'h0;
            tick    <= 1'b0;
        end else begin
            tick <= src && (div_reg == `SBA_QUARTER);
            if (src) begin
                div_reg <= div_reg + 2'h1;
            end
        end
    end
endmodule : sba_tick

//--- rtl/sba_top.sv
// arbiter and bit timer for a single-wire serial bus, apb register slave
// assumes rx_line and tx_internal are synchronous-enough levels
// and prescaled_tick is a one-cycle pulse per prescaled serial clock
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "sba_cfg.svh"
module sba_top #(
    parameter int CNT_W = 9
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_line,
    input  wire logic        tx_internal,
    input  wire logic        prescaled_tick,
    output logic             tx_pin,
    output logic             irq
);
    sba_pkg::sba_apb_req_t req;
    sba_pkg::sba_stat_t    st;

    logic [1:0]       mode_reg;
    logic             clk_sel_reg;
    logic             lost_reg;
    logic             fin_reg;
    logic             run_reg;
    logic             ovfl_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic             armed_reg;
    logic             rx_meta_reg;
    logic             rx_sync_reg;
    logic             rx_prev_reg;
    logic             tx_prev_reg;
    logic [`SBA_IRQ_W-1:0] irq_stat_reg;
    logic [`SBA_IRQ_W-1:0] irq_en_reg;
    logic             tick;
    logic             ctl_wr;
    logic             wr_en;
    logic             rd_en;
    logic             rx_fall;
    logic             rx_rise;
    logic             tx_rise;
    logic             tx_fall;
    logic             fin_set;
    logic             ovfl_set;
    logic             lost_set;
    logic             mode_hi_clr;
    logic [CNT_W-1:0] sample_at;

    // map a register address to its read value
    function automatic logic [31:0] read_mux(input logic [11:0] a,
                                             input sba_pkg::sba_stat_t s,
                                             input logic [2:0] ist,
                                             input logic [2:0] ien);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `SBA_ADDR_CTL: begin
                v[`SBA_CTL_OVFL]    = s.ovfl;
                v[`SBA_CTL_RUN]     = s.run;
                v[`SBA_CTL_FIN]     = s.fin;
                v[`SBA_CTL_CLK]     = s.clk_sel;
                v[`SBA_CTL_LOST]    = s.lost;
                v[`SBA_CTL_MSB]     = s.count[8];
                v[`SBA_CTL_MODE_HI:`SBA_CTL_MODE_LO] = s.mode;
            end
            `SBA_ADDR_DAT:      v[7:0] = s.count[7:0];
            `SBA_ADDR_IRQ_STAT: v[2:0] = ist;
            `SBA_ADDR_IRQ_EN:   v[2:0] = ien;
            default:            v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_mux

    // true for any address this slave decodes
    function automatic logic mapped(input logic [11:0] a);
        return (a == `SBA_ADDR_CTL) || (a == `SBA_ADDR_DAT) ||
               (a == `SBA_ADDR_IRQ_STAT) || (a == `SBA_ADDR_IRQ_EN) ||
               (a == `SBA_ADDR_IRQ_CLR);
    endfunction : mapped

    // bundle bus inputs and visible state
    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};
    assign st  = '{ovfl: ovfl_reg, run: run_reg, fin: fin_reg,
                   clk_sel: clk_sel_reg, lost: lost_reg,
                   count: 9'(cnt_reg), mode: mode_reg};

    // bus decodes: reads in setup, writes in access; slave answers in the first access cycle
    assign wr_en  = req.psel && req.penable && req.pwrite && pready;
    assign rd_en  = req.psel && !req.penable && !req.pwrite;
    assign ctl_wr = wr_en && (req.paddr == `SBA_ADDR_CTL);
    assign mode_hi_clr = ctl_wr && !req.pwdata[`SBA_CTL_MODE_HI];

    // rx edge detection runs on the second sync stage; tx edges on tx_internal directly
    assign rx_fall = rx_prev_reg && !rx_sync_reg;
    assign rx_rise = !rx_prev_reg && rx_sync_reg;
    assign tx_rise = !tx_prev_reg && tx_internal;
    assign tx_fall = tx_prev_reg && !tx_internal;
    assign sample_at = clk_sel_reg ? CNT_W'(`SBA_SAMPLE_PRE)
                                   : CNT_W'(`SBA_SAMPLE_BUS);

    // quarter-rate counting tick
    sba_tick u_tick (
        .pclk           (pclk),
        .presetn        (presetn),
        .clk_sel        (clk_sel_reg),
        .prescaled_tick (prescaled_tick),
        .clear          (ctl_wr),
        .tick           (tick)
    );

    // apb answer: one wait-free access phase, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= req.psel && !req.penable;
            pslverr <= req.psel && !req.penable && !mapped(req.paddr);
            if (rd_en) begin
                prdata <= read_mux(req.paddr, st, irq_stat_reg, irq_en_reg);
            end
        end
    end

    // software-owned control fields; reserved mode kept by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg    <= `SBA_MODE_IDLE;
            clk_sel_reg <= 1'b0;
        end else if (ctl_wr) begin
            mode_reg    <= req.pwdata[`SBA_CTL_MODE_HI:`SBA_CTL_MODE_LO];
            clk_sel_reg <= req.pwdata[`SBA_CTL_CLK];
        end
    end

    // two-stage receive synchroniser and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
            tx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= rx_line;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
            tx_prev_reg <= tx_internal;
        end
    end

    // measurement and arbitration sequencing of the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= '0;
            run_reg   <= 1'b0;
            armed_reg <= 1'b0;
        end else if (ctl_wr || mode_reg == `SBA_MODE_IDLE) begin
            cnt_reg   <= '0;
            run_reg   <= 1'b0;
            armed_reg <= 1'b0;
        end else if (mode_reg == `SBA_MODE_MEASURE) begin
            if (!clk_sel_reg) begin
                if (rx_fall && !run_reg && !fin_reg) begin
                    run_reg <= 1'b1;
                end else if (rx_fall && run_reg) begin
                    run_reg <= 1'b0;
                end
            end else begin
                if (!rx_sync_reg && !run_reg && !fin_reg) begin
                    run_reg <= 1'b1;
                end else if (rx_rise && run_reg) begin
                    run_reg <= 1'b0;
                end
            end
            if (run_reg && tick) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end else if (mode_reg == `SBA_MODE_ARB) begin
            if (tx_rise) begin
                cnt_reg   <= '0;
                run_reg   <= 1'b1;
                armed_reg <= 1'b1;
            end else if (tx_fall && armed_reg) begin
                cnt_reg   <= '0;
                run_reg   <= 1'b0;
                armed_reg <= 1'b0;
            end else if (run_reg && tick) begin
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg == sample_at) begin
                    armed_reg <= 1'b0;           // sample taken
                end
            end
        end
    end

    // event terms for the flags
    assign fin_set  = (mode_reg == `SBA_MODE_MEASURE) && run_reg &&
                      (clk_sel_reg ? rx_rise : rx_fall);
    assign ovfl_set = run_reg && tick && (&cnt_reg);
    assign lost_set = (mode_reg == `SBA_MODE_ARB) && run_reg && armed_reg &&
                      tick && (cnt_reg == sample_at) && !rx_sync_reg;

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fin_reg  <= 1'b0;
            ovfl_reg <= 1'b0;
            lost_reg <= 1'b0;
        end else begin
            fin_reg  <= fin_set  || (fin_reg  && !ctl_wr);
            ovfl_reg <= ovfl_set || (ovfl_reg && !ctl_wr);
            lost_reg <= lost_set || (lost_reg && !mode_hi_clr);
        end
    end

    // transmit pin held recessive while arbitration is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pin <= 1'b1;
        end else begin
            tx_pin <= tx_internal || lost_set || lost_reg;
        end
    end

    // interrupt status, enable and write-one-to-clear; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
            irq_en_reg   <= '0;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                             ~((wr_en && req.paddr == `SBA_ADDR_IRQ_CLR) ?
                               req.pwdata[2:0] : 3'h0)) |
                            {lost_set, ovfl_set, fin_set};
            if (wr_en && req.paddr == `SBA_ADDR_IRQ_EN) begin
                irq_en_reg <= req.pwdata[2:0];
            end
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end
endmodule : sba_top

//--- verification/sba_bus_node.sv
// other node sharing the single-wire bus with our transmit pin
// assumes a pull-up on the wire: it idles recessive high
`timescale 1ns/1ps
module sba_bus_node (
    input  wire logic tx_pin,
    input  wire logic dominant,
    output logic      rx_line
);
    // wired-and: whoever pulls low wins, a released wire goes to the pull-up
    assign rx_line = tx_pin & ~dominant;
endmodule : sba_bus_node

//--- verification/sba_top_asserts.sv
// checker for the arbiter register slave and its transmit pin
// assumes it is bound to sba_top and the cfg header is on the path
`timescale 1ns/1ps
`include "sba_cfg.svh"
module sba_top_asserts #(
    parameter int CNT_W = 9
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_line,
    input wire logic        tx_internal,
    input wire logic        prescaled_tick,
    input wire logic        tx_pin,
    input wire logic        irq
);
    logic wr_ctl;
    logic rd_ctl;
    logic rd_dat;
    // a finished control write, and fresh read setups of both registers
    assign wr_ctl = psel && penable && pready && pwrite
                    && paddr == `SBA_ADDR_CTL;
    assign rd_ctl = psel && !penable && !pwrite && paddr == `SBA_ADDR_CTL;
    assign rd_dat = psel && !penable && !pwrite && paddr == `SBA_ADDR_DAT;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_setup: assert property (
        psel && !penable |=> pready) else $error("ready late");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready too long");
    a_tx_forced: assert property (
        !tx_pin |-> !$past(tx_internal)) else $error("tx pin low unasked");
    a_idle_zero: assert property (
        wr_ctl && pwdata[1:0] == 2'h0 ##2 rd_dat |=> prdata[7:0] == 8'h00)
        else $error("idle count not zero");
    a_idle_stop: assert property (
        wr_ctl && pwdata[1:0] == 2'h0 ##2 rd_ctl |=> !prdata[6])
        else $error("idle counter runs");
    a_wr_clears: assert property (
        wr_ctl ##2 rd_ctl |=> prdata[7] == 1'b0 && prdata[5] == 1'b0
        && prdata[2] == 1'b0) else $error("flags survive write");
    a_lost_clear: assert property (
        wr_ctl && !pwdata[1] ##2 rd_ctl |=> !prdata[3])
        else $error("lost not cleared");
    a_mode_back: assert property (
        wr_ctl ##2 rd_ctl |=> prdata[1:0] == $past(pwdata[1:0], 3)
        && prdata[4] == $past(pwdata[4], 3)) else $error("mode readback");
endmodule : sba_top_asserts

bind sba_top sba_top_asserts #(.CNT_W(CNT_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .tx_internal(tx_internal), .prescaled_tick(prescaled_tick),
    .tx_pin(tx_pin), .irq(irq));

//--- verification/sba_top_tb.sv
// bench for sba_top: registers, bit timing, overflow and arbitration
// assumes the checker binds itself and the cfg header is on the path
`timescale 1ns/1ps
`include "sba_cfg.svh"
module sba_top_tb;
    logic                  pclk;
    logic                  presetn;
    sba_pkg::sba_apb_req_t req;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rx_line;
    logic                  txi;
    logic                  tick;
    logic                  tx_pin;
    logic                  irq;
    logic                  hold;
    logic [31:0]           q;
    logic                  e;
    int                    num_errors;
    int                    n_tests;

    sba_top #(.CNT_W(9)) dut (
        .pclk(pclk), .presetn(presetn), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
        .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_line(rx_line), .tx_internal(txi),
        .prescaled_tick(tick), .tx_pin(tx_pin), .irq(irq));
    sba_bus_node node (.tx_pin(tx_pin), .dominant(hold), .rx_line(rx_line));

    // clock, and a prescaled pulse on every second edge
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) tick <= ~tick;

    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string w, input logic [31:0] s,
                       input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", w, x, s);
        end
    endtask : chk

    // one apb transfer; software never asks for the reserved mode
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        // look at pready mid-cycle, where it is settled, then finish at
        // the rising edge that samples it high
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        req <= '0;
        if (k >= 50) begin
            num_errors++;
            final_report();
        end
    endtask : apb

    // a hung sequence ends the run here; apb ends a hung transfer itself
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end

    initial begin
        presetn = 1'b0;
        req = '0;
        txi = 1'b1;
        hold = 1'b0;
        tick = 1'b0;
        num_errors = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `SBA_ADDR_CTL, 0);
        chk("ctl reset", q, 0);
        apb(0, `SBA_ADDR_DAT, 0);
        chk("dat reset", q, 0);
        apb(0, 12'h0ff, 0);
        chk("unmapped", 32'(e), 1);
        apb(1, `SBA_ADDR_IRQ_EN, 1);
        // baud recovery: falling edges 40 cycles apart give ten ticks
        apb(1, `SBA_ADDR_CTL, 32'h01);
        hold <= 1'b1;
        repeat (10) @(posedge pclk);
        hold <= 1'b0;
        repeat (30) @(posedge pclk);
        hold <= 1'b1;
        repeat (5) @(posedge pclk);
        hold <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(0, `SBA_ADDR_DAT, 0);
        chk("sel0 count", 32'(q >= 9 && q <= 11), 1);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("sel0 ctl", q, 32'h21);
        chk("irq fin", 32'(irq), 1);
        apb(1, `SBA_ADDR_IRQ_EN, 0);
        // break length: line already low when measuring starts
        hold <= 1'b1;
        apb(1, `SBA_ADDR_CTL, 32'h11);
        repeat (20) @(posedge pclk);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("sel1 run", 32'(q[6]), 1);
        repeat (60) @(posedge pclk);
        hold <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(0, `SBA_ADDR_DAT, 0);
        chk("sel1 count", 32'(q >= 8 && q <= 13), 1);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("sel1 ctl", q, 32'h31);
        // one falling edge, then long enough to wrap the nine bits
        apb(1, `SBA_ADDR_CTL, 32'h01);
        hold <= 1'b1;
        repeat (2070) @(posedge pclk);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("ovfl", 32'(q[7]), 1);
        chk("irq masked", 32'(irq), 0);
        apb(1, `SBA_ADDR_IRQ_EN, 2);
        repeat (2) @(posedge pclk);
        chk("irq ovfl", 32'(irq), 1);
        apb(1, `SBA_ADDR_IRQ_CLR, 7);
        repeat (2) @(posedge pclk);
        chk("irq clr", 32'(irq), 0);
        // arbitration: won with a quiet line, then lost to a dominant node
        hold <= 1'b0;
        txi <= 1'b0;
        apb(1, `SBA_ADDR_CTL, 32'h02);
        txi <= 1'b1;
        repeat (260) @(posedge pclk);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("arb won", 32'(q[3]), 0);
        // tx drops before the sample: counter zeroed and stopped
        txi <= 1'b0;
        repeat (3) @(posedge pclk);
        txi <= 1'b1;
        repeat (20) @(posedge pclk);
        txi <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("early tx run", 32'(q[6]), 0);
        apb(0, `SBA_ADDR_DAT, 0);
        chk("early tx cnt", q, 0);
        txi <= 1'b0;
        repeat (3) @(posedge pclk);
        txi <= 1'b1;
        hold <= 1'b1;
        repeat (260) @(posedge pclk);
        txi <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("tx forced", 32'(tx_pin), 1);
        apb(0, `SBA_ADDR_CTL, 0);
        chk("arb lost", 32'(q[3]), 1);
        apb(1, `SBA_ADDR_CTL, 0);
        hold <= 1'b0;
        apb(0, `SBA_ADDR_CTL, 0);
        chk("ctl idle", q, 0);
        final_report();
    end
endmodule : sba_top_tb
